//--- design/output_line_map.svh
/*
  register offsets, table sizes and the source reset value for the output line source selector.
  assumes a plain register port with byte-free word addressing.
*/
`ifndef OUTPUT_LINE_MAP_SVH
`define OUTPUT_LINE_MAP_SVH
`define OLS_ADDR_W 4
`define OLS_REG_SOURCE 4'h0
`define OLS_REG_INVERT 4'h1
`define OLS_REG_SWLEVEL 4'h2
`define OLS_REG_SLOTSEL 4'h3
`define OLS_REG_SEQTABLE 4'h4
`define OLS_REG_SEQINDEX 4'h5
`define OLS_REG_DIRECTION 4'h6
`define OLS_REG_STATUS 4'h7
`define OLS_SEQ_SETS 16
`define OLS_SEQ_IDX_W 4
`define OLS_SLOTS 2
`define OLS_SRC_RESET 3'h0
`endif

//--- design/output_line_pkg.sv
/*
  types for the output line source selector.
  assumes output_line_map.svh is visible to users of the constants.
*/
`default_nettype none
package output_line_pkg;
  typedef enum logic [2:0] {
    SRC_EXPOSURE = 3'h0,
    SRC_FRAME_WAIT = 3'h1,
    SRC_ACQ_WAIT = 3'h2,
    SRC_FLASH = 3'h3,
    SRC_TIMER = 3'h4,
    SRC_SOFTWARE = 3'h5,
    SRC_SEQUENCED = 3'h6
  } drive_source_t;
endpackage : output_line_pkg
`default_nettype wire

//--- design/source_mux.sv
/*
  source multiplexer with registered output and polarity inverter.
  assumes all inputs are synchronous to mclk.
*/
`default_nettype none
module source_mux
  import output_line_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] sel,
  input wire logic invert,
  input wire logic [6:0] sources,
  output logic pinLevel
);
  logic chosen;
  always_comb
  begin
    case (sel)
      SRC_EXPOSURE: chosen = sources[0];
      SRC_FRAME_WAIT: chosen = sources[1];
      SRC_ACQ_WAIT: chosen = sources[2];
      SRC_FLASH: chosen = sources[3];
      SRC_TIMER: chosen = sources[4];
      SRC_SOFTWARE: chosen = sources[5];
      SRC_SEQUENCED: chosen = sources[6];
      default: chosen = sources[0];
    endcase
  end
  // registered output avoids mux glitches
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      pinLevel <= 1'b0;
    else
      pinLevel <= chosen ^ invert; // R5 R11 R13
  end
endmodule : source_mux
`default_nettype wire

//--- design/output_line_source_select.sv
/*
  output line source selection with software and sequenced levels.
  two software slots, one level per sequencer set, registered pin drive.
  assumes internal signals and sequencer strobes share mclk; register port on mclk.
  assumes the host sets the direction bit before it picks a source.
*/
//
// Overview of operation
// R1: pin driven from exactly one selected source
// R2: reset selects exposure window as source
// R3: software mode drives stored software level
// R4: software level unaffected by sequencer advance
// R5: software level applied before the inverter
// R6: each set stores level, applied at advance
// R7: sequencer changes sequenced level with frame start
// R8: host sets direction to output before configuring
// R9: two software slots, index selects one
// R10: software level reads back the stored level of the currently selected slot
// R11: inversion reverses drive control mapping
// R12: seven internal sources are selectable
// R13: setting changes take effect next cycle
`include "output_line_map.svh"
`default_nettype none
module output_line_source_select
  import output_line_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`OLS_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic exposureWindowSignal,
  input wire logic frameTriggerWait,
  input wire logic acqTriggerWait,
  input wire logic flashWindow,
  input wire logic timerActive,
  input wire logic seqAdvance,
  input wire logic [`OLS_SEQ_IDX_W-1:0] seqNextSet,
  output logic gpioOutputPin,
  output logic pinDirectionSetting
);
  // ==========================================================
  // configuration registers
  logic [2:0] driveSourceSelect_r;
  logic outputPolarityInvert_r;
  logic [`OLS_SLOTS-1:0] softwareOutputLevel_r;
  logic softwareOutputSlotSelect_r;
  logic [`OLS_SEQ_SETS-1:0] seqLevels_r;
  logic [`OLS_SEQ_IDX_W-1:0] seqIndex_r;
  logic sequencedOutputLevel_r;
  logic direction_r;
  logic srcLegal;
  logic [6:0] srcVector;
  logic [31:0] regRdata_nxt;
  logic wrSource;
  logic wrInvert;
  logic wrLevel;
  logic wrSlot;
  logic wrSeqTable;
  logic wrSeqIndex;
  logic wrDir;

  // ==========================================================
  // write strobe decode
  always_comb
  begin
    wrSource = 1'b0;
    wrInvert = 1'b0;
    wrLevel = 1'b0;
    wrSlot = 1'b0;
    wrSeqTable = 1'b0;
    wrSeqIndex = 1'b0;
    wrDir = 1'b0;
    if (regWr)
    begin
      case (regAddr)
        `OLS_REG_SOURCE: wrSource = 1'b1;
        `OLS_REG_INVERT: wrInvert = 1'b1;
        `OLS_REG_SWLEVEL: wrLevel = 1'b1;
        `OLS_REG_SLOTSEL: wrSlot = 1'b1;
        `OLS_REG_SEQTABLE: wrSeqTable = 1'b1;
        `OLS_REG_SEQINDEX: wrSeqIndex = 1'b1;
        `OLS_REG_DIRECTION: wrDir = 1'b1;
        default: wrDir = 1'b0;
      endcase
    end
  end

  // out-of-range source codes leave the selection alone
  assign srcLegal = (regWdata[31:3] == 29'h0) && (regWdata[2:0] <= SRC_SEQUENCED);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      driveSourceSelect_r <= `OLS_SRC_RESET; // R2
    else if (wrSource && srcLegal)
      driveSourceSelect_r <= regWdata[2:0]; // R1 R12
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      outputPolarityInvert_r <= 1'b0;
    else if (wrInvert)
      outputPolarityInvert_r <= regWdata[0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      softwareOutputSlotSelect_r <= 1'b0;
    else if (wrSlot)
      softwareOutputSlotSelect_r <= regWdata[0]; // R9
  end

  // ==========================================================
  // software level slots, untouched by sequencer
  genvar gi;
  generate
    for (gi = 0; gi < `OLS_SLOTS; gi = gi + 1)
    begin : g_slot
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          softwareOutputLevel_r[gi] <= 1'b0;
        else if (wrLevel && (softwareOutputSlotSelect_r == 1'(gi)))
          softwareOutputLevel_r[gi] <= regWdata[0]; // R3 R4 R9
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      direction_r <= 1'b1;
    else if (wrDir)
      direction_r <= regWdata[0];
  end

  // ==========================================================
  // sequencer set levels
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      seqIndex_r <= '0;
    else if (wrSeqIndex)
      seqIndex_r <= regWdata[`OLS_SEQ_IDX_W-1:0];
  end

  // one level flop per sequencer set
  genvar si;
  generate
    for (si = 0; si < `OLS_SEQ_SETS; si = si + 1)
    begin : g_set
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          seqLevels_r[si] <= 1'b0;
        else if (wrSeqTable && (seqIndex_r == (`OLS_SEQ_IDX_W)'(si)))
          seqLevels_r[si] <= regWdata[0]; // R6
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      sequencedOutputLevel_r <= 1'b0;
    else if (seqAdvance)
      sequencedOutputLevel_r <= seqLevels_r[seqNextSet]; // R6 R7
  end

  // ==========================================================
  // output mux
  logic softwareLevel;
  assign softwareLevel = softwareOutputLevel_r[softwareOutputSlotSelect_r];

  // bit order follows the source codes
  assign srcVector = {sequencedOutputLevel_r, softwareLevel, timerActive, flashWindow,
                      acqTriggerWait, frameTriggerWait, exposureWindowSignal}; // R12

  source_mux u_mux (
    .mclk(mclk),
    .rst_b(rst_b),
    .sel(driveSourceSelect_r),
    .invert(outputPolarityInvert_r),
    .sources(srcVector),
    .pinLevel(gpioOutputPin)
  );

  assign pinDirectionSetting = direction_r;

  // ==========================================================
  // read port
  always_comb
  begin
    regRdata_nxt = 32'h0;
    if (regRd)
    begin
      case (regAddr)
        `OLS_REG_SOURCE: regRdata_nxt = {29'h0, driveSourceSelect_r};
        `OLS_REG_INVERT: regRdata_nxt = {31'h0, outputPolarityInvert_r};
        `OLS_REG_SWLEVEL: regRdata_nxt = {31'h0, softwareLevel}; // R10
        `OLS_REG_SLOTSEL: regRdata_nxt = {31'h0, softwareOutputSlotSelect_r};
        `OLS_REG_SEQTABLE: regRdata_nxt = {31'h0, seqLevels_r[seqIndex_r]};
        `OLS_REG_SEQINDEX: regRdata_nxt = {28'h0, seqIndex_r};
        `OLS_REG_DIRECTION: regRdata_nxt = {31'h0, direction_r};
        `OLS_REG_STATUS: regRdata_nxt = {30'h0, sequencedOutputLevel_r, gpioOutputPin};
        default: regRdata_nxt = 32'h0;
      endcase
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      regRdata <= 32'h0;
    else
      regRdata <= regRdata_nxt;
  end
endmodule : output_line_source_select
`default_nettype wire

//--- verif/output_line_props.sv
/* port assertions for the output line selector.
   assumes binding to output_line_source_select, single clock. */
`default_nettype none
module output_line_props
  import output_line_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic exposureWindowSignal,
  input wire logic frameTriggerWait,
  input wire logic acqTriggerWait,
  input wire logic flashWindow,
  input wire logic timerActive,
  input wire logic gpioOutputPin,
  input wire logic pinDirectionSetting
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadow settings
  logic [2:0] srcR;
  logic invR;
  wire logic [4:0] srcVec = {timerActive, flashWindow, acqTriggerWait, frameTriggerWait, exposureWindowSignal};
  wire logic selBit = invR ^ srcVec[srcR];
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      {srcR, invR} <= 4'h0;
    else if (regWr && regAddr == 4'h0 && regWdata < 32'h7)
      srcR <= regWdata[2:0];
    else if (regWr && regAddr == 4'h1)
      invR <= regWdata[0];
  end
  // ==========
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence fixedSrc;
    srcR < 3'h5;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0) !rst_b |=> !gpioOutputPin && pinDirectionSetting)
    else $error("pin or direction wrong in reset");
  reset_exp_a: assert property (disable iff (1'b0) $rose(rst_b) |=> gpioOutputPin == $past(exposureWindowSignal))
    else $error("pin not on exposure after reset");
  pin_follows_a: assert property (fixedSrc |=> gpioOutputPin == $past(selBit))
    else $error("pin not selected source");
  rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read");
  unmapped_read_a: assert property (regRd && regAddr > 4'h7 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  status_pin_a: assert property (regRd && regAddr == 4'h7 |=> regRdata[0] == $past(gpioOutputPin))
    else $error("status pin bit wrong");
  inv_rb_a: assert property (regRd && regAddr == 4'h1 |=> regRdata == {31'h0, $past(invR)})
    else $error("invert readback wrong");
  src_rb_a: assert property (regRd && regAddr == 4'h0 |=> regRdata == {29'h0, $past(srcR)})
    else $error("source readback wrong");
endmodule : output_line_props
bind output_line_source_select output_line_props chk_u (.mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .exposureWindowSignal, .frameTriggerWait, .acqTriggerWait, .flashWindow, .timerActive,
  .gpioOutputPin, .pinDirectionSetting);
`default_nettype wire

//--- verif/lamp_model.sv
/* lamp behind the opto output.
   assumes the drive control from the selector on mclk. */
`default_nettype none
module lamp_model
(
  input wire logic mclk,
  input wire logic driveOn,
  output logic lampLit
);
  timeunit 1ns;
  timeprecision 1ps;
  // lamp follows the transistor drive one mclk cycle later
  always_ff @(posedge mclk)
  begin
    lampLit <= driveOn;
  end
endmodule : lamp_model
`default_nettype wire

//--- verif/output_line_source_select_tb.sv
/* self-checking bench for the output line selector.
   assumes design, package and checker compiled before. */
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module output_line_source_select_tb
  import output_line_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [4:0] srcs = 5'h0;
  logic seqAdvance = 1'b0;
  logic [3:0] seqNextSet = 4'h0;
  logic [31:0] regRdata;
  logic gpioOutputPin, pinDirectionSetting, lampLit, inv;
  int errors = 0;
  int n_checks = 0;
  int s;
  output_line_source_select dut_u (.mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .exposureWindowSignal(srcs[0]), .frameTriggerWait(srcs[1]), .acqTriggerWait(srcs[2]),
    .flashWindow(srcs[3]), .timerActive(srcs[4]), .seqAdvance, .seqNextSet, .gpioOutputPin, .pinDirectionSetting);
  lamp_model lamp_u (.mclk, .driveOn(gpioOutputPin), .lampLit);
  always #5 mclk = ~mclk;
  // ==========
  // bus and check tasks
  function automatic logic expPin(input logic lv, input logic iv);
    return lv ^ iv;
  endfunction : expPin
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 `CHK(nm, e, regRdata)
  endtask : rd
  task automatic pin(input logic e);
    repeat (2) @(posedge mclk);
    #1 `CHK("pin", e, gpioOutputPin)
    `CHK("lamp", e, lampLit)
  endtask : pin
  task automatic adv(input logic [3:0] n, input logic e);
    @(posedge mclk);
    seqAdvance <= 1'b1;
    seqNextSet <= n;
    @(posedge mclk);
    seqAdvance <= 1'b0;
    pin(e);
  endtask : adv
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // ==========
  // tests
  initial
  begin
    #50000;
    errors++;
    stop_test();
  end
  initial
  begin
    s = $urandom(32'h71de372a);
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h6, 32'h1, "dir");
    wr(4'h6, 32'h1);
    `CHK("dirpin", 1'b1, pinDirectionSetting)
    rd(4'h0, 32'h0, "src");
    for (int i = 0; i < 20; i++)
    begin
      inv = 1'($urandom);
      @(posedge mclk);
      srcs <= 5'($urandom);
      wr(4'h1, {31'h0, inv});
      wr(4'h0, 32'(i % 5));
      pin(expPin(srcs[i % 5], inv));
    end
    wr(4'h3, 32'h1);
    wr(4'h2, 32'h0);
    wr(4'h3, 32'h0);
    wr(4'h2, 32'h1);
    wr(4'h1, 32'h1);
    wr(4'h0, 32'(SRC_SOFTWARE));
    pin(expPin(1'b1, 1'b1));
    wr(4'h3, 32'h1);
    pin(expPin(1'b0, 1'b1));
    rd(4'h2, 32'h0, "level");
    wr(4'h5, 32'h3);
    wr(4'h4, 32'h1);
    wr(4'h5, 32'h4);
    wr(4'h4, 32'h0);
    wr(4'h1, 32'h0);
    rd(4'h1, 32'h0, "inv");
    wr(4'h0, 32'(SRC_SEQUENCED));
    adv(4'h3, 1'b1);
    adv(4'h4, 1'b0);
    wr(4'h3, 32'h0);
    wr(4'h0, 32'(SRC_SOFTWARE));
    pin(expPin(1'b1, 1'b0));
    rd(4'h2, 32'h1, "level");
    rd(4'h7, 32'h1, "status");
    wr(4'h0, 32'h7);
    wr(4'h0, 32'h8);
    rd(4'h0, 32'h5, "src");
    rd(4'h9, 32'h0, "unmapped");
    stop_test();
  end
endmodule : output_line_source_select_tb
`default_nettype wire
